// >>> design/iom_pkg.sv
/*
  Shared constants for the increment / OR / move / branch execution core:
  word widths, instruction field positions, opcode codes and reset values.
  Assumes the mid-range 14-bit instruction word with a 7-bit file address.
*/
package iom_pkg;

  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int JMP_W = 11;
  localparam int OPC_W = 6;

  // Field positions inside the instruction word and the PC high latch
  localparam int OPC_MSB = 13;
  localparam int OPC_LSB = 8;
  localparam int DEST_BIT = 7;
  localparam int JMP_SEL_MSB = 13;
  localparam int JMP_SEL_LSB = 11;
  localparam int LATCH_HI_MSB = 4;
  localparam int LATCH_HI_LSB = 3;

  // Byte-oriented file operations and OR-literal, selected by the upper six bits; jump by the upper three
  localparam logic [OPC_W-1:0] OPC_INCR_SKIP = 6'h0F;
  localparam logic [OPC_W-1:0] OPC_INCR_FILE = 6'h0A;
  localparam logic [OPC_W-1:0] OPC_OR_FILE = 6'h04;
  localparam logic [OPC_W-1:0] OPC_MOVE_FILE = 6'h08;
  localparam logic [OPC_W-1:0] OPC_OR_LIT = 6'h38;
  localparam logic [2:0] OPC_JUMP = 3'h5;

  // No-operation: all bits zero apart from the don't-care pair
  localparam logic [INSTR_W-1:0] NOP_MASK = 14'h3F9F;
  localparam logic [INSTR_W-1:0] NOP_CODE = 14'h0000;

  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;

  typedef enum logic [1:0] {
    IOM_EXEC = 2'h1,
    IOM_FLUSH = 2'h2
  } iom_state_t;

endpackage

// >>> design/iom_core.sv
/*
  Execution core for increment (plain and skip-on-zero), unconditional
  jump, inclusive OR with literal or file, move of a file register and
  no-operation. One instruction cycle per ref_clk rising edge.
  Assumes: instr is the word fetched at pc_r, valid in the same cycle;
  file_rd_data is the file register addressed by instr[6:0], read
  combinationally by the surroundings; file writes are applied by the
  surroundings on the edge after file_wr_en_r is seen.
*/
`timescale 1ns/10ps

module iom_core #(
  parameter logic [iom_pkg::PC_W-1:0] RESET_VEC = iom_pkg::PC_RESET
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [iom_pkg::INSTR_W-1:0] instr,
  input wire logic [iom_pkg::DATA_W-1:0] file_rd_data,
  input wire logic [iom_pkg::DATA_W-1:0] pc_high_latch,
  output logic [iom_pkg::PC_W-1:0] pc_r,
  output logic [iom_pkg::DATA_W-1:0] w_r,
  output logic z_r,
  output logic file_wr_en_r,
  output logic [iom_pkg::ADDR_W-1:0] file_wr_addr_r,
  output logic [iom_pkg::DATA_W-1:0] file_wr_data_r,
  output logic flush_r
);
  import iom_pkg::*;

  iom_state_t state_r;
  iom_state_t state_nxt;
  logic [PC_W-1:0] jmp_tgt_r;
  logic jmp_pend_r;

  wire logic executing;
  wire logic [OPC_W-1:0] opc;
  wire logic to_file;
  wire logic [ADDR_W-1:0] faddr;
  wire logic [DATA_W-1:0] lit;
  wire logic [PC_W-1:0] jmp_tgt;
  wire logic is_incr_skip;
  wire logic is_incr_file;
  wire logic is_or_file;
  wire logic is_move_file;
  wire logic is_or_lit;
  wire logic is_jump;
  wire logic is_nop;
  wire logic fwd_hit;
  wire logic [DATA_W-1:0] fval;
  wire logic [DATA_W-1:0] inc_val;
  wire logic [DATA_W-1:0] or_file_val;
  wire logic [DATA_W-1:0] or_lit_val;
  wire logic byte_op;
  wire logic [DATA_W-1:0] byte_res;
  wire logic skip_taken;
  wire logic z_upd;
  wire logic [DATA_W-1:0] z_src;
  wire logic file_we_nxt;
  wire logic w_we_nxt;
  wire logic [DATA_W-1:0] w_nxt;
  wire logic z_nxt;
  wire logic [PC_W-1:0] pc_seq;
  wire logic [PC_W-1:0] pc_nxt;

  // Decode; a flushed cycle decodes as nothing at all
  assign executing = (state_r == IOM_EXEC);
  assign opc = instr[OPC_MSB:OPC_LSB];
  assign to_file = instr[DEST_BIT];
  assign faddr = instr[ADDR_W-1:0];
  assign lit = instr[DATA_W-1:0];
  assign is_incr_skip = executing && (opc == OPC_INCR_SKIP);
  assign is_incr_file = executing && (opc == OPC_INCR_FILE);
  assign is_or_file = executing && (opc == OPC_OR_FILE);
  assign is_move_file = executing && (opc == OPC_MOVE_FILE);
  assign is_or_lit = executing && (opc == OPC_OR_LIT);
  assign is_jump = executing && (instr[JMP_SEL_MSB:JMP_SEL_LSB] == OPC_JUMP);
  assign is_nop = executing && ((instr & NOP_MASK) == NOP_CODE);

  // Jump target: latch bits above, operand below
  assign jmp_tgt = {pc_high_latch[LATCH_HI_MSB:LATCH_HI_LSB],
                    instr[JMP_W-1:0]};

  // The file write lands one edge late, so a back-to-back read of the
  // same address would see stale data without this bypass
  assign fwd_hit = file_wr_en_r && (file_wr_addr_r == faddr);
  assign fval = fwd_hit ? file_wr_data_r : file_rd_data;

  assign inc_val = fval + DATA_ONE;
  assign or_file_val = w_r | fval;
  assign or_lit_val = w_r | lit;

  assign byte_op = is_incr_skip || is_incr_file || is_or_file
                   || is_move_file;
  assign byte_res = is_or_file ? or_file_val
                  : is_move_file ? fval
                  : inc_val;

  // Destination select by d for every byte operation
  assign file_we_nxt = byte_op && to_file;
  assign w_we_nxt = (byte_op && !to_file) || is_or_lit;
  assign w_nxt = is_or_lit ? or_lit_val : byte_res;

  // Skip-on-zero, jump and no-op leave the flag alone; the others set it from the result
  assign skip_taken = is_incr_skip && (inc_val == DATA_ZERO);
  assign z_upd = is_incr_file || is_or_file || is_move_file
                 || is_or_lit;
  assign z_src = is_or_lit ? or_lit_val : byte_res;
  assign z_nxt = z_upd ? (z_src == DATA_ZERO) : z_r;

  // Both two-cycle cases advance to the already fetched word, then flush
  // it; the jump only redirects at the end of the flush cycle
  assign pc_seq = pc_r + PC_STEP;
  assign pc_nxt = (!executing && jmp_pend_r) ? jmp_tgt_r : pc_seq;

  always_comb begin
    unique case (state_r)
      IOM_EXEC: begin
        state_nxt = (is_jump || skip_taken) ? IOM_FLUSH
                                            : IOM_EXEC;
      end
      IOM_FLUSH: begin
        state_nxt = IOM_EXEC;
      end
      default: begin
        state_nxt = IOM_EXEC;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= IOM_EXEC;
      flush_r <= 1'b0;
      jmp_pend_r <= 1'b0;
      jmp_tgt_r <= PC_RESET;
      pc_r <= RESET_VEC;
    end else begin
      state_r <= state_nxt;
      flush_r <= (state_nxt == IOM_FLUSH);
      jmp_pend_r <= is_jump;
      jmp_tgt_r <= is_jump ? jmp_tgt : jmp_tgt_r;
      pc_r <= pc_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_r <= W_RESET;
      z_r <= 1'b0;
      file_wr_en_r <= 1'b0;
      file_wr_addr_r <= '0;
      file_wr_data_r <= DATA_ZERO;
    end else begin
      w_r <= w_we_nxt ? w_nxt : w_r;
      z_r <= z_nxt;
      file_wr_en_r <= file_we_nxt;
      file_wr_addr_r <= file_we_nxt ? faddr : file_wr_addr_r;
      file_wr_data_r <= file_we_nxt ? byte_res : file_wr_data_r;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Increment-and-skip
  a_incr_skip_flags: assert property (
    is_incr_skip |=> $stable(z_r))
    else $error("increment-and-skip changed the zero flag");

  a_incr_skip_dest: assert property (
    is_incr_skip && to_file |=>
      file_wr_en_r && file_wr_data_r == $past(inc_val) && $stable(w_r))
    else $error("increment-and-skip file write wrong");

  a_incr_skip_w: assert property (
    is_incr_skip && !to_file |=>
      w_r == $past(inc_val) && !file_wr_en_r)
    else $error("increment-and-skip W write wrong");

  // Two cycles: the fetched word is dropped and the counter steps twice
  a_skip_discard: assert property (
    skip_taken |=> flush_r ##1
      (!flush_r && pc_r == PC_W'($past(pc_r, 2) + 2'd2)))
    else $error("zero skip did not discard one word");

  a_no_skip_run: assert property (
    is_incr_skip && !skip_taken |=> !flush_r)
    else $error("non-zero increment skipped");

  // A discarded word must leave every result register untouched
  a_flush_quiet: assert property (
    flush_r |=> $stable(w_r) && $stable(z_r) && !file_wr_en_r)
    else $error("discarded word changed state");

  a_flush_single: assert property (
    flush_r |=> !flush_r)
    else $error("more than one word discarded");

  // Jump
  a_jump_target: assert property (
    is_jump |=> ##1 pc_r[JMP_W-1:0]
      == $past(instr[JMP_W-1:0], 2))
    else $error("jump target low bits wrong");

  a_jump_high_bits: assert property (
    is_jump |=> ##1 pc_r[PC_W-1:JMP_W]
      == $past(pc_high_latch[LATCH_HI_MSB:LATCH_HI_LSB], 2))
    else $error("jump high bits not from latch");

  // The first jump cycle only walks onto the word it is about to drop
  a_jump_seq_step: assert property (
    is_jump |=> pc_r == PC_W'($past(pc_r) + PC_STEP))
    else $error("jump did not step past the fetched word");

  a_jump_two_cycle: assert property (
    is_jump |=> (flush_r && $stable(z_r) && $stable(w_r)
      && !file_wr_en_r) ##1 (!flush_r && $stable(z_r)))
    else $error("jump not two quiet cycles");

  // OR operations
  a_or_literal: assert property (
    is_or_lit |=> w_r == ($past(w_r) | $past(lit))
      && z_r == (w_r == DATA_ZERO))
    else $error("OR-literal result or zero wrong");

  // Literal form has no file side effect
  a_or_lit_no_file: assert property (
    is_or_lit |=> !file_wr_en_r && !flush_r)
    else $error("OR-literal wrote a file register");

  // The destination is judged by the d bit of the word just executed
  a_or_file_dest: assert property (
    is_or_file |=> ($past(to_file) ? file_wr_en_r
      : w_r == ($past(w_r) | $past(fval)))
      && z_r == (($past(w_r) | $past(fval)) == DATA_ZERO))
    else $error("OR-file destination or zero wrong");

  a_or_file_back: assert property (
    is_or_file && to_file |=> file_wr_addr_r == $past(faddr)
      && file_wr_data_r == ($past(w_r) | $past(fval)) && $stable(w_r))
    else $error("OR-file write-back wrong");

  // Increment
  a_incr_zero: assert property (
    is_incr_file |=> z_r == ($past(inc_val) == DATA_ZERO)
      && (file_wr_en_r == $past(to_file)))
    else $error("increment zero flag or destination wrong");

  // Result checked against the operand, not against the shared adder
  a_incr_value: assert property (
    is_incr_file |=> ($past(to_file) ? file_wr_data_r : w_r)
      == DATA_W'($past(fval) + DATA_ONE))
    else $error("increment result wrong");

  // Move
  a_move_dest: assert property (
    is_move_file && !to_file |=> w_r == $past(fval)
      && !file_wr_en_r)
    else $error("move-file to W wrong");

  a_move_back: assert property (
    is_move_file && to_file |=> file_wr_en_r && $stable(w_r)
      && file_wr_addr_r == $past(faddr) && file_wr_data_r == $past(fval))
    else $error("move-file write-back wrong");

  // A write-back move is the idiom for testing a register for zero
  a_move_zero: assert property (
    is_move_file |=> z_r == ($past(fval) == DATA_ZERO))
    else $error("move-file zero flag wrong");

  // Sampled reset keeps the release edge, where the idle word decodes
  // as a no-op, from starting an attempt against reset values
  a_nop_quiet: assert property (
    rst_n && is_nop |=> pc_r == PC_W'($past(pc_r) + PC_STEP)
      && $stable(w_r) && $stable(z_r) && !file_wr_en_r && !flush_r)
    else $error("no-operation changed state");

  // Nothing outside the byte operations may strobe a file write
  a_wr_en_cause: assert property (
    file_wr_en_r |-> $past(byte_op && to_file))
    else $error("file write without a byte operation");

  // Main scenarios: zero skip, jump, zero test, bypass, literal zero
  c_skip_taken: cover property (skip_taken ##2 executing);
  c_jump: cover property (is_jump ##1 flush_r ##1 executing);
  c_move_test: cover property (is_move_file && to_file ##1 z_r);
  c_or_file_back: cover property (is_or_file && to_file && fwd_hit);
  c_or_lit_zero: cover property (is_or_lit ##1 z_r);

endmodule

// >>> verif/tb.sv
/*
  Self-checking bench for iom_core: random instruction stream with
  hand-picked corners, each result checked against a bench model.
  Assumes the bench plays file memory and commits a write on the strobe.
*/
`timescale 1ns/10ps
module tb;
  import iom_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [INSTR_W-1:0] instr = NOP_CODE;
  logic [DATA_W-1:0] pc_high_latch = DATA_ZERO;
  logic [DATA_W-1:0] file_rd_data;
  logic [PC_W-1:0] pc_r;
  logic [DATA_W-1:0] w_r;
  logic z_r;
  logic file_wr_en_r;
  logic [ADDR_W-1:0] file_wr_addr_r;
  logic [DATA_W-1:0] file_wr_data_r;
  logic flush_r;
  logic [7:0] fmem [128];
  logic [7:0] efile [128];
  logic [12:0] epc = PC_RESET;
  logic [12:0] etgt = PC_RESET;
  logic [7:0] ew = 8'h00;
  logic [7:0] edata = 8'h00;
  logic [6:0] eaddr = 7'h00;
  logic ez = 1'b0;
  logic ewen = 1'b0;
  logic eflush = 1'b0;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [13:0] corner [15] = '{14'h3800, 14'h0F85, 14'h38FF, 14'h0F06,
    14'h2ABC, 14'h0885, 14'h0A07, 14'h0487, 14'h0807, 14'h0F87, 14'h2FFF,
    14'h2800, 14'h2800, 14'h0000, 14'h0060};

  iom_core i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .instr(instr),
    .file_rd_data(file_rd_data), .pc_high_latch(pc_high_latch),
    .pc_r(pc_r), .w_r(w_r), .z_r(z_r), .file_wr_en_r(file_wr_en_r),
    .file_wr_addr_r(file_wr_addr_r), .file_wr_data_r(file_wr_data_r),
    .flush_r(flush_r));

  always #10 ref_clk = ~ref_clk;
  assign file_rd_data = fmem[instr[6:0]];

  always @(posedge ref_clk) begin
    if (file_wr_en_r === 1'b1)
      fmem[file_wr_addr_r] <= file_wr_data_r;
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(string name, logic [12:0] e, logic [12:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  task check;
    chk("pc", epc, pc_r);
    chk("w", 13'(ew), 13'(w_r));
    chk("z", 13'(ez), 13'(z_r));
    chk("flush", 13'(eflush), 13'(flush_r));
    chk("wr_en", 13'(ewen), 13'(file_wr_en_r));
    if (ewen) begin
      chk("wr_addr", 13'(eaddr), 13'(file_wr_addr_r));
      chk("wr_data", 13'(edata), 13'(file_wr_data_r));
    end
  endtask

  task put(logic [6:0] a, logic d, logic [7:0] r);
    if (d) begin
      ewen = 1'b1;
      eaddr = a;
      edata = r;
      efile[a] = r;
    end else
      ew = r;
  endtask

  // Checks the previous word's result, then predicts this word's
  task automatic exec(logic [13:0] iw);
    logic [7:0] f;
    logic [7:0] r;
    logic [7:0] lat;
    lat = 8'($urandom);
    f = efile[iw[6:0]];
    @(posedge ref_clk);
    instr <= iw;
    // Latch only moves with a live jump so its sampling edge is moot
    if (iw[13:11] == OPC_JUMP && !eflush)
      pc_high_latch <= lat;
    @(negedge ref_clk);
    check();
    ewen = 1'b0;
    epc = eflush ? etgt : epc + 13'h0001;
    if (eflush)
      eflush = 1'b0;
    else case (iw[13:8])
      OPC_INCR_SKIP: begin
        r = f + 8'h01;
        put(iw[6:0], iw[7], r);
        eflush = (r == 8'h00);
        etgt = epc + 13'h0001;
      end
      OPC_INCR_FILE: begin
        r = f + 8'h01;
        put(iw[6:0], iw[7], r);
        ez = (r == 8'h00);
      end
      OPC_OR_FILE: begin
        r = ew | f;
        put(iw[6:0], iw[7], r);
        ez = (r == 8'h00);
      end
      OPC_MOVE_FILE: begin
        put(iw[6:0], iw[7], f);
        ez = (f == 8'h00);
      end
      OPC_OR_LIT: begin
        ew = ew | iw[7:0];
        ez = (ew == 8'h00);
      end
      default: if (iw[13:11] == OPC_JUMP) begin
        eflush = 1'b1;
        etgt = {lat[4:3], iw[10:0]};
      end
    endcase
  endtask

  function automatic logic [13:0] rnd_instr();
    logic [7:0] a;
    a = {1'($urandom), 7'($urandom_range(0, 15))};
    case ($urandom_range(0, 6))
      0: return {OPC_INCR_SKIP, a};
      1: return {OPC_INCR_FILE, a};
      2: return {OPC_OR_FILE, a};
      3: return {OPC_MOVE_FILE, a};
      4: return {OPC_OR_LIT, 8'($urandom)};
      5: return {OPC_JUMP, 11'($urandom)};
      default: return NOP_CODE;
    endcase
  endfunction

  initial begin
    void'($urandom(33041));
    for (int i = 0; i < 128; i++) begin
      fmem[i] = (i == 5 || i == 6) ? 8'hFF : (i == 7 ? 8'h00 : 8'($urandom));
      efile[i] = fmem[i];
    end
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    check();
    @(posedge ref_clk);
    rst_n <= 1'b1;
    epc = PC_STEP;
    $display("test reset done");
    foreach (corner[i])
      exec(corner[i]);
    $display("test corners done");
    repeat (400)
      exec(rnd_instr());
    exec(NOP_CODE);
    // The last word's result is only seen one edge later
    @(posedge ref_clk);
    @(negedge ref_clk);
    check();
    $display("test random done");
    report_and_stop();
  end
endmodule
